/* File: common/cmb_pkg.sv */
// Constants shared by the memory bus requester
package cmb_pkg;
    localparam int addr_w = 17;
    localparam int data_w = 18;
    // Register map on the Avalon-MM slave (word offsets as byte addresses)
    localparam logic [3:0] reg_ctrl = 4'h0;
    localparam logic [3:0] reg_addr = 4'h4;
    localparam logic [3:0] reg_wdata = 4'h8;
    localparam logic [3:0] reg_rdata = 4'hc;
    localparam logic [3:0] reg_status = 4'h0;
    // Control word fields
    localparam int ctrl_start = 0;
    localparam int ctrl_mode_lo = 1;
    localparam int ctrl_mode_hi = 2;
    // Mode codes: bit0 read line, bit1 write line
    localparam logic [1:0] mode_rr = 2'h1;
    localparam logic [1:0] mode_cw = 2'h2;
    localparam logic [1:0] mode_rpw = 2'h3;
    localparam logic [1:0] mode_none = 2'h0;
    // Status word fields
    localparam int st_busy = 0;
    localparam int st_done = 1;
    localparam int st_parity = 2;
    // Timing
    localparam int clk_period_ns = 10;
    localparam int settle_ns = 50;
    localparam int settle_cyc = (settle_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [31:0] zero_word = 32'h0;
endpackage

/* File: verilog/cmb_requester.sv */
// Requester end of an asynchronous core memory bus, driven by software over Avalon-MM
// Functional notes
// R1: Bank responds only on matching address bits 03-04
// R2: Control lines active low, data low is one
// R3: Requester drives five controls and 17-bit address
// R4: 18-bit data plus optional parity bidirectional
// R5: Read, write, both select three cycle modes
// R6: Busy bank holds shared busy, blocks others
// R7: Start only when busy clear, address, mode driven
// R8: Request after 50 ns address/mode settling
// R9: Bank latches, acknowledges address about 110 ns
// R10: Address acknowledge raises busy, withdraws request
// R11: Bank drops address acknowledge when request falls
// R12: Read/restore data on bus after 150 ns
// R13: Capture read data only on read-restart
// R14: Read-restart never in clear/write cycles
// R15: Read/restore rewrites via write-enable state
// R16: After read capture, assert data-ack and release
// R17: Data-ack removes bank data from bus
// R18: Release-ack only after release and write-enable
// R19: Drop release on release-ack; bank then drops
// R20: Bank ends cycle by releasing busy
// R21: In write modes, release means data placed
// R22: Clear/write: data, 50 ns, then release
// R23: Read/pause/write: pause until release, then write
// R24: Unselected bank drives nothing
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cmb_requester (
    input wire logic clock, // 100 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read strobe
    input wire logic avs_write, // Write strobe
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    output logic [cmb_pkg::addr_w-1:0] mdl_out, // Address drive on the shared lines, low means one
    output logic [cmb_pkg::addr_w:0] mdl_oe_n, // Unused upper bit kept for data width
    input wire logic [cmb_pkg::data_w-1:0] mdl_in, // Data lines sensed, low means one
    output logic [cmb_pkg::data_w-1:0] data_out_n, // Write data drive, low means one
    output logic parity_out_n, // Parity drive, low means one
    output logic parity_oe_n, // Parity enable, low drives
    input wire logic parity_in_n, // Parity sensed
    output logic read_mode_line_n, // Read mode, active low
    output logic write_mode_line_n, // Write mode, active low
    output logic req_n, // Memory request, active low
    output logic data_ack_n, // Data acknowledge, active low
    output logic release_line_n, // Release, active low
    input wire logic busy_n, // Shared busy, active low
    input wire logic addr_ack_n, // Address acknowledge, active low
    input wire logic read_restart_n, // Read-restart, active low
    input wire logic release_accept_n // Release acknowledge, active low
);
    typedef enum logic [7:0] {
        cmb_idle = 8'h01,
        cmb_setup = 8'h02,
        cmb_req = 8'h04,
        cmb_wait_rd = 8'h08,
        cmb_wdata = 8'h10,
        cmb_rel = 8'h20,
        cmb_unrel = 8'h40,
        cmb_done = 8'h80
    } cmb_state_t;

    cmb_state_t state, next_state;
    logic [1:0] mode, next_mode;
    logic [cmb_pkg::addr_w-1:0] addr, next_addr;
    logic [cmb_pkg::data_w-1:0] wdata, next_wdata, rdata, next_rdata;
    logic wpar, next_wpar, rpar, next_rpar, done, next_done;
    logic [7:0] cnt, next_cnt;
    logic read_seen, next_read_seen;
    logic [31:0] rd_mux;
    logic rd_hold, next_rd_hold;
    logic [31:0] next_readdata;

    wire logic busy = !busy_n;
    wire logic aack = !addr_ack_n;
    wire logic rrst = !read_restart_n;
    wire logic racc = !release_accept_n;
    wire logic start_wr = avs_write && avs_address == cmb_pkg::reg_ctrl && avs_writedata[cmb_pkg::ctrl_start];
    wire logic [1:0] wr_mode = avs_writedata[cmb_pkg::ctrl_mode_hi:cmb_pkg::ctrl_mode_lo];

    // Reads take one wait state so registered data stands when waitrequest drops; a start while a cycle runs is dropped
    assign avs_waitrequest = avs_read && !rd_hold;

    always_comb begin
        rd_mux = cmb_pkg::zero_word;
        case (avs_address)
            cmb_pkg::reg_status: rd_mux = {29'h0, rpar, done, state != cmb_idle};
            cmb_pkg::reg_addr: rd_mux = {15'h0, addr};
            cmb_pkg::reg_wdata: rd_mux = {13'h0, wpar, wdata};
            cmb_pkg::reg_rdata: rd_mux = {13'h0, rpar, rdata};
            default: rd_mux = cmb_pkg::zero_word;
        endcase
        next_rd_hold = avs_read && !rd_hold;
        next_readdata = next_rd_hold ? rd_mux : avs_readdata;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            avs_readdata <= cmb_pkg::zero_word;
            rd_hold <= 1'b0;
        end else begin
            avs_readdata <= next_readdata;
            rd_hold <= next_rd_hold;
        end
    end

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_addr = addr;
        next_wdata = wdata;
        next_wpar = wpar;
        next_rdata = rdata;
        next_rpar = rpar;
        next_done = done;
        next_cnt = cnt;
        next_read_seen = read_seen;
        if (avs_write && avs_address == cmb_pkg::reg_addr && state == cmb_idle) begin
            next_addr = avs_writedata[cmb_pkg::addr_w-1:0];
        end
        if (avs_write && avs_address == cmb_pkg::reg_wdata && state == cmb_idle) begin
            next_wdata = avs_writedata[cmb_pkg::data_w-1:0];
            next_wpar = avs_writedata[cmb_pkg::data_w];
        end
        case (state)
            cmb_idle: begin
                if (start_wr && wr_mode != cmb_pkg::mode_none) begin // R5
                    next_mode = wr_mode;
                    next_done = 1'b0;
                    next_read_seen = 1'b0;
                    next_cnt = 8'h0;
                    next_state = cmb_setup;
                end
            end
            cmb_setup: begin
                // Hold off while any bank is busy, then let lines settle
                if (busy) begin // R7
                    next_cnt = 8'h0;
                end else if (cnt >= 8'(cmb_pkg::settle_cyc)) begin // R8
                    next_state = cmb_req;
                end else begin
                    next_cnt = cnt + 8'h1;
                end
            end
            cmb_req: begin
                if (aack) begin // R10
                    next_cnt = 8'h0;
                    next_state = (mode == cmb_pkg::mode_cw) ? cmb_wdata : cmb_wait_rd; // R21
                end
            end
            cmb_wait_rd: begin
                if (rrst) begin // R13
                    next_rdata = ~mdl_in;
                    next_rpar = !parity_in_n;
                    next_read_seen = 1'b1;
                    next_cnt = 8'h0;
                    next_state = (mode == cmb_pkg::mode_rr) ? cmb_rel : cmb_wdata; // R16 R23
                end
            end
            cmb_wdata: begin
                if (cnt >= 8'(cmb_pkg::settle_cyc)) begin // R22
                    next_state = cmb_rel;
                end else begin
                    next_cnt = cnt + 8'h1;
                end
            end
            cmb_rel: begin
                if (racc) begin // R19
                    next_state = cmb_unrel;
                end
            end
            cmb_unrel: begin
                if (!racc) begin // R19
                    next_state = cmb_done;
                end
            end
            cmb_done: begin
                if (!busy) begin // R20
                    next_done = 1'b1;
                    next_state = cmb_idle;
                end
            end
            default: next_state = cmb_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= cmb_idle;
            mode <= cmb_pkg::mode_none;
            addr <= '0;
            wdata <= '0;
            wpar <= 1'b0;
            rdata <= '0;
            rpar <= 1'b0;
            done <= 1'b0;
            cnt <= 8'h0;
            read_seen <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            addr <= next_addr;
            wdata <= next_wdata;
            wpar <= next_wpar;
            rdata <= next_rdata;
            rpar <= next_rpar;
            done <= next_done;
            cnt <= next_cnt;
            read_seen <= next_read_seen;
        end
    end

    wire logic addr_phase = state == cmb_setup || state == cmb_req;
    wire logic data_phase = mode != cmb_pkg::mode_rr && (state == cmb_wdata || state == cmb_rel);
    wire logic in_cycle = state != cmb_idle && state != cmb_done;

    // Address and write data share the lines; ground means one
    assign mdl_out = ~addr; // R2 R3
    assign mdl_oe_n = {1'b1, {cmb_pkg::addr_w{!addr_phase}}};
    assign data_out_n = ~wdata; // R4
    assign parity_out_n = !wpar;
    assign parity_oe_n = !data_phase;
    assign read_mode_line_n = !(in_cycle && mode[0]); // R5
    assign write_mode_line_n = !(in_cycle && mode[1]);
    assign req_n = !(state == cmb_req); // R8 R10
    assign data_ack_n = !(read_seen && state != cmb_idle && state != cmb_done && state != cmb_wait_rd); // R16
    assign release_line_n = !(state == cmb_rel); // R16 R21

    // Request and release handshakes as seen from this side
    sequence s_req_seen;
        !req_n && aack;
    endsequence

    sequence s_rel_seen;
        !release_line_n && racc;
    endsequence

    // Write data on the lines while release is held back for the settling time
    sequence s_data_settle;
        (!parity_oe_n && release_line_n) [*6];
    endsequence

    property p_req_after_settle;
        @(posedge clock) disable iff (rst)
        $fell(req_n) |-> !$past(mdl_oe_n[0], 5);
    endproperty
    a_req_after_settle: assert property (p_req_after_settle) else $error("request before settling"); // R8

    property p_req_quiet;
        @(posedge clock) disable iff (rst)
        ($fell(read_mode_line_n) || $fell(write_mode_line_n)) |-> req_n [*6];
    endproperty
    a_req_quiet: assert property (p_req_quiet) else $error("request raised with the mode lines"); // R8

    property p_start_idle;
        @(posedge clock) disable iff (rst)
        $fell(req_n) |-> !$past(busy);
    endproperty
    a_start_idle: assert property (p_start_idle) else $error("request while busy"); // R7

    property p_lines_hold;
        @(posedge clock) disable iff (rst)
        !req_n |-> $stable(mdl_out) && $stable(read_mode_line_n) && $stable(write_mode_line_n);
    endproperty
    a_lines_hold: assert property (p_lines_hold) else $error("address or mode moved during request"); // R8

    property p_mode_lines;
        @(posedge clock) disable iff (rst)
        !req_n |-> mode != cmb_pkg::mode_none && {write_mode_line_n, read_mode_line_n} == ~mode;
    endproperty
    a_mode_lines: assert property (p_mode_lines) else $error("mode lines do not match the cycle"); // R5

    property p_addr_drive;
        @(posedge clock) disable iff (rst)
        !req_n |-> mdl_oe_n[cmb_pkg::addr_w-1:0] == '0;
    endproperty
    a_addr_drive: assert property (p_addr_drive) else $error("address not driven during request"); // R3

    property p_req_drop;
        @(posedge clock) disable iff (rst)
        s_req_seen |=> req_n;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request held after acknowledge"); // R10

    property p_rel_drop;
        @(posedge clock) disable iff (rst)
        s_rel_seen |=> release_line_n;
    endproperty
    a_rel_drop: assert property (p_rel_drop) else $error("release held after accept"); // R19

    property p_rel_hold;
        @(posedge clock) disable iff (rst)
        (!release_line_n && !racc) |=> !release_line_n;
    endproperty
    a_rel_hold: assert property (p_rel_hold) else $error("release dropped before accept"); // R19

    property p_cw_wait;
        @(posedge clock) disable iff (rst)
        ($fell(release_line_n) && mode == cmb_pkg::mode_cw) |-> !$past(parity_oe_n, 5);
    endproperty
    a_cw_wait: assert property (p_cw_wait) else $error("release too early"); // R22

    property p_cw_flow;
        @(posedge clock) disable iff (rst)
        (!req_n && aack && mode == cmb_pkg::mode_cw) |=> s_data_settle ##1 !release_line_n;
    endproperty
    a_cw_flow: assert property (p_cw_flow) else $error("write data not placed before release"); // R21

    property p_rpw_flow;
        @(posedge clock) disable iff (rst)
        (state == cmb_wait_rd && rrst && mode == cmb_pkg::mode_rpw) |=>
            (!data_ack_n && release_line_n) ##0 s_data_settle ##1 !release_line_n;
    endproperty
    a_rpw_flow: assert property (p_rpw_flow) else $error("pause sequence broken"); // R23

    property p_rr_acks;
        @(posedge clock) disable iff (rst)
        ($fell(release_line_n) && mode == cmb_pkg::mode_rr) |-> !data_ack_n;
    endproperty
    a_rr_acks: assert property (p_rr_acks) else $error("release without data ack"); // R16

    property p_rr_capture;
        @(posedge clock) disable iff (rst)
        (state == cmb_wait_rd && rrst && mode == cmb_pkg::mode_rr) |=>
            !data_ack_n && !release_line_n && parity_oe_n;
    endproperty
    a_rr_capture: assert property (p_rr_capture) else $error("data ack and release not together"); // R16

    property p_capture_only;
        @(posedge clock) disable iff (rst)
        !rrst |=> $stable(rdata);
    endproperty
    a_capture_only: assert property (p_capture_only) else $error("read data taken without read-restart"); // R13

    property p_write_data;
        @(posedge clock) disable iff (rst)
        !parity_oe_n |-> mode != cmb_pkg::mode_rr && mdl_oe_n[0];
    endproperty
    a_write_data: assert property (p_write_data) else $error("data driven outside a write cycle"); // R4

    property p_done_wait;
        @(posedge clock) disable iff (rst)
        $rose(done) |-> !$past(busy);
    endproperty
    a_done_wait: assert property (p_done_wait) else $error("cycle closed while busy"); // R20
endmodule // cmb_requester
`default_nettype wire

/* File: verification/cmb_bank_model.sv */
// Behavioural memory bank answering the requester
`timescale 1ns/1ps
`default_nettype none
module cmb_bank_model #(
    parameter logic [1:0] sel = 2'h0, // Select switches
    parameter int ack_dly = 11 // Request to acknowledge
) (
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic [17:0] bus_n, // Data lines
    input wire logic par_n, // Parity line
    input wire logic rd_n, // Read mode
    input wire logic wr_n, // Write mode
    input wire logic req_n, // Request
    input wire logic dack_n, // Data ack
    input wire logic rel_n, // Release
    input wire logic busy_n, // Shared busy
    output logic [18:0] drv_n, // Parity and data, ones when off
    output logic busy_o_n, // Busy
    output logic ack_n, // Address ack
    output logic rrst_n, // Read-restart
    output logic acc_n // Release accept
);
    logic [18:0] mem [logic [16:0]];
    logic [16:0] a;
    logic rd;
    logic wr;
    initial begin
        {drv_n, busy_o_n, ack_n, rrst_n, acc_n} = '1;
        forever begin
            @(posedge clock);
            // Lines count from the top, so lines 03 and 04 are bits 14 and 13
            if (!rst && !req_n && busy_n && ~bus_n[14:13] == sel) begin
                a = ~bus_n[16:0];
                rd = !rd_n;
                wr = !wr_n;
                repeat (ack_dly) @(posedge clock);
                ack_n <= 0;
                busy_o_n <= 0;
                while (!req_n) @(posedge clock);
                ack_n <= 1;
                if (rd) begin
                    repeat (15) @(posedge clock);
                    drv_n <= mem.exists(a) ? ~mem[a] : '1;
                    repeat (10) @(posedge clock);
                    rrst_n <= 0;
                    while (dack_n) @(posedge clock);
                    drv_n <= '1;
                end
                while (rel_n) @(posedge clock);
                if (wr) mem[a] = ~{par_n, bus_n};
                acc_n <= 0;
                while (!rel_n) @(posedge clock);
                {acc_n, rrst_n} <= 2'h3;
                @(posedge clock);
                busy_o_n <= 1;
            end
        end
    end
endmodule // cmb_bank_model
`default_nettype wire

/* File: verification/tb_core_memory_bus_handshake.sv */
// Self-checking bench: requester driving two bank models
`timescale 1ns/1ps
`default_nettype none
module tb_core_memory_bus_handshake;
    typedef struct {logic [1:0] m; logic [16:0] a; logic [18:0] w; logic [31:0] e;} cmb_row_t;
    logic clock, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, st, rd;
    logic [16:0] mdl_out, cur_a;
    logic [17:0] mdl_oe_n, data_out_n, bus_n;
    logic [18:0] held;
    logic [1:0] cur_m;
    logic par_out_n, par_oe_n, par_n, rd_n, wr_n, req_n, req_q, dack_n, rel_n;
    wire logic [18:0] d [2];
    wire logic [3:0] b [2];
    wire logic [3:0] ctl = b[0] & b[1];
    int fail_count, n_tests, cyc, stab;
    cmb_row_t rows [9] = '{'{cmb_pkg::mode_cw, 17'h18fff, 19'h7ffff, 32'h0},
        '{cmb_pkg::mode_rr, 17'h18fff, 19'h0, 32'h7ffff}, '{cmb_pkg::mode_rr, 17'h18fff, 19'h0, 32'h7ffff},
        '{cmb_pkg::mode_rpw, 17'h18fff, 19'h2a5a5, 32'h7ffff}, '{cmb_pkg::mode_rr, 17'h18fff, 19'h0, 32'h2a5a5},
        '{cmb_pkg::mode_cw, 17'h02005, 19'h15a5a, 32'h0}, '{cmb_pkg::mode_cw, 17'h00005, 19'h00001, 32'h0},
        '{cmb_pkg::mode_rr, 17'h02005, 19'h0, 32'h15a5a}, '{cmb_pkg::mode_rr, 17'h00005, 19'h0, 32'h1}};
    // Open-collector lines: any driver pulls low, released lines float high
    assign bus_n = (par_oe_n ? '1 : data_out_n) & {1'b1, mdl_out | mdl_oe_n[16:0]} & d[0][17:0] & d[1][17:0];
    assign par_n = (par_oe_n | par_out_n) & d[0][18] & d[1][18];
    cmb_requester cmb_requester_i (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mdl_out(mdl_out), .mdl_oe_n(mdl_oe_n), .mdl_in(bus_n),
        .data_out_n(data_out_n), .parity_out_n(par_out_n), .parity_oe_n(par_oe_n), .parity_in_n(par_n),
        .read_mode_line_n(rd_n), .write_mode_line_n(wr_n), .req_n(req_n), .data_ack_n(dack_n),
        .release_line_n(rel_n), .busy_n(ctl[3]), .addr_ack_n(ctl[2]), .read_restart_n(ctl[1]),
        .release_accept_n(ctl[0]));
    for (genvar i = 0; i < 2; i++) begin : g
        cmb_bank_model #(.sel(2'(i)), .ack_dly(11 + 11 * i)) bank_i (.clock(clock), .rst(rst), .bus_n(bus_n),
            .par_n(par_n), .rd_n(rd_n), .wr_n(wr_n), .req_n(req_n), .dack_n(dack_n), .rel_n(rel_n),
            .busy_n(ctl[3]), .drv_n(d[i]), .busy_o_n(b[i][3]), .ack_n(b[i][2]), .rrst_n(b[i][1]), .acc_n(b[i][0]));
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt();
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
    endtask
    task automatic bw(input logic [3:0] a, input logic [31:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        wt();
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic br(input logic [3:0] a, output logic [31:0] v);
        avs_address <= a;
        avs_read <= 1'b1;
        wt();
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic run(input logic [1:0] m, input logic [16:0] a, input logic [18:0] w, input logic p);
        cur_a = a;
        cur_m = m;
        bw(cmb_pkg::reg_addr, {15'h0, a});
        bw(cmb_pkg::reg_wdata, {13'h0, w});
        bw(cmb_pkg::reg_ctrl, {29'h0, m, 1'b1});
        if (p) bw(cmb_pkg::reg_addr, {15'h0, a ^ 17'h02000});
        do begin
            br(cmb_pkg::reg_status, st);
        end while (st[cmb_pkg::st_done] !== 1'b1);
        chk("status", 32'h2, {30'h0, st[cmb_pkg::st_done], st[cmb_pkg::st_busy]});
        br(cmb_pkg::reg_rdata, rd);
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        held <= {mdl_out, rd_n, wr_n};
        stab <= ({mdl_out, rd_n, wr_n} === held) ? stab + 1 : 0;
        req_q <= req_n;
        if (!rst && req_q === 1'b1 && req_n === 1'b0) begin
            chk("settle", 32'h1, {31'h0, stab >= 5 && ctl[3] === 1'b1});
            chk("addr mode", {13'h0, ~cur_a, ~cur_m}, {13'h0, mdl_out, wr_n, rd_n});
        end
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        rst = 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        foreach (rows[i]) begin
            run(rows[i].m, rows[i].a, rows[i].w, 1'b0);
            if (rows[i].m !== cmb_pkg::mode_cw) chk("read data", rows[i].e, rd);
        end
        run(cmb_pkg::mode_rr, 17'h00005, 19'h0, 1'b1);
        chk("refused address", 32'h1, rd);
        br(4'h2, rd);
        chk("unmapped", 32'h0, rd);
        bw(cmb_pkg::reg_ctrl, {29'h0, cmb_pkg::mode_rr, 1'b1});
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("reset lines", 32'h1f, {27'h0, req_n, dack_n, rel_n, rd_n, wr_n});
        br(cmb_pkg::reg_status, st);
        chk("reset status", 32'h0, st);
        close_out();
    end
endmodule // tb_core_memory_bus_handshake
`default_nettype wire
